// ===== hdl/rtcbg_alarm_match.sv
// Per-field alarm comparison and first-match detection.
`timescale 1ns/100ps
`default_nettype none
module rtcbg_alarm_match (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire logic [5:0][7:0]       compareReg,
	input  wire rtcbg_pkg::rtcbg_time_t timeNow,
	input  wire logic                  secondsTick,
	output logic                       hit
);

	logic [5:0][7:0] timeFields;
	logic [5:0]      fieldMatch;
	logic            prevMatch;

	assign timeFields = timeNow;

	genvar i;
	generate
		for (i = 0; i < rtcbg_pkg::ALARM_FIELDS; i++) begin : g_field
			assign fieldMatch[i] = !compareReg[i][rtcbg_pkg::FIELD_ENABLE_BIT] ||
				(compareReg[i][6:0] == timeFields[i][6:0]);
		end
	endgenerate

	// Only the transition into a full match fires, so an ignored seconds field gives one hit at the roll to 00.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prevMatch <= 1'b0;
			hit       <= 1'b0;
		end else if (ce) begin
			hit <= 1'b0;
			if (secondsTick) begin
				prevMatch <= &fieldMatch;
				hit       <= (&fieldMatch) && !prevMatch;
			end
		end
	end

endmodule // rtcbg_alarm_match
`default_nettype wire

// ===== hdl/rtcbg_pkg.sv
// Constants, types and register map of the backup bus gating and alarm block.
// What this block does
// - The serial bus stops answering whenever the main supply is below the reset threshold, in every mode.
// - Both mode bits clear: backup starts at the trip threshold and bus and memory are blocked on battery.
// - Inhibit clear, switchover set: backup below battery, bus usable on battery only with battery and supply above reset.
// - With inhibit set and switchover clear, the block behaves exactly as with both mode bits clear.
// - Both mode bits set: backup below battery, bus works only while supply is above both reset and battery.
// - The interrupt output keeps working while on battery in every mode.
// - Bit 7 of an alarm compare register enables the field and the low bits hold BCD, so zero means ignored.
// - An alarm interrupt is produced only while the alarm enable bit, bit 5 of interrupt control, is set.
// - The alarm fires when time first equals all enabled fields, with seconds ignored at the 59 to 00 roll.
// - A match sets the alarm flag in status and pulls the interrupt output low.
// - With the repeat select bit clear, one match holds the output low as a single event.
// - With the repeat select bit set, each match gives one low pulse on the output.
// - After power-up both mode bits are clear.
// - In legacy modes the chip runs from battery whenever supply is below the trip threshold, whatever the battery level.
package rtcbg_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int PULSE_TIME_NS   = 250;
	localparam int PULSE_CYCLES    = (PULSE_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 : PULSE_TIME_NS / CLOCK_PERIOD_NS;
	localparam int PULSE_COUNT_W   = 8;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] REG_ALARM0_SECONDS_MATCH = 8'h00;
	localparam logic [7:0] REG_ALARM0_WEEKDAY_MATCH = 8'h05;
	localparam logic [7:0] REG_INTERRUPT_CONTROL    = 8'h06;
	localparam logic [7:0] REG_STATUS               = 8'h07;
	localparam logic [7:0] REG_BACKUP_CONFIG        = 8'h08;
	localparam int         ALARM_FIELDS             = 6;
	localparam int         FIELD_ENABLE_BIT         = 7;
	localparam int         INTCTL_ALARM0_ENABLE_BIT = 5;
	localparam int         INTCTL_REPEAT_SELECT_BIT = 7;
	localparam int         STATUS_ON_BATTERY_BIT    = 0;
	localparam int         STATUS_BUS_ENABLE_BIT    = 1;
	localparam int         STATUS_ALARM0_FLAG_BIT   = 5;
	localparam int         CFG_SWITCHOVER_BIT       = 0;
	localparam int         CFG_INHIBIT_BIT          = 1;
	localparam logic [7:0] RESET_VALUE              = 8'h00;
	localparam logic [6:0] DEVICE_ADDRESS           = 7'h50;  // Arbitrary value.

	// ----------------------------------------
	// Serial bus
	// ----------------------------------------
	localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_ACK_DONE = 4'h9;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] weekday;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rtcbg_time_t;

	typedef struct packed {
		logic vddBelowReset;
		logic vddBelowBattery;
		logic vddBelowTrip;
		logic batteryBelowReset;
		logic batteryBelowTrip;
	} rtcbg_supply_t;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_DEVICE     = 3'b001,
		ST_WORD_ADDR  = 3'b010,
		ST_WRITE_DATA = 3'b011,
		ST_READ_DATA  = 3'b100
	} rtcbg_bus_state_t;

endpackage

// ===== hdl/rtcbg_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none
module rtcbg_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic firstStage;
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					firstStage <= 1'b0;
					syncOut[i] <= 1'b0;
				end else if (ce) begin
					firstStage <= asyncIn[i];
					syncOut[i] <= firstStage;
				end
			end
		end
	endgenerate

endmodule // rtcbg_sync
`default_nettype wire

// ===== hdl/rtcbg_top.sv
// Serial register port, backup bus gating and alarm output of the real-time clock.
`timescale 1ns/100ps
`default_nettype none
module rtcbg_top #(
	parameter int PULSE_CYCLES = rtcbg_pkg::PULSE_CYCLES
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    ce,
	input  wire logic                    scl,
	input  wire logic                    sdaIn,
	output logic                         sdaOut,
	output logic                         sdaOe,
	input  wire rtcbg_pkg::rtcbg_supply_t supplyRaw,
	input  wire rtcbg_pkg::rtcbg_time_t   timeNow,
	input  wire logic                    secondsTick,
	output logic                         interruptFreqOutput_n,
	output logic                         memoryAccessEnable,
	output logic                         busEnable,
	output logic                         onBattery,
	output logic                         alarm0Flag
);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	rtcbg_pkg::rtcbg_supply_t supply;
	logic                     sclS;
	logic                     sdaS;
	logic                     sclPrev;
	logic                     sdaPrev;

	rtcbg_sync #(
		.WIDTH   (7)
	) u_sync (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.asyncIn ({scl, sdaIn, supplyRaw}),
		.syncOut ({sclS, sdaS, supply})
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else if (ce) begin
			sclPrev <= sclS;
			sdaPrev <= sdaS;
		end
	end

	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	assign sclRise   = sclS && !sclPrev;
	assign sclFall   = !sclS && sclPrev;
	assign startCond = sclS && sclPrev && sdaPrev && !sdaS;
	assign stopCond  = sclS && sclPrev && !sdaPrev && sdaS;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [5:0][7:0] alarmReg;
	logic [7:0]      interruptControl;
	logic [7:0]      backupConfig;
	logic            alarm0Enable;
	logic            interruptRepeatSelect;
	logic            backupSwitchoverSelect;
	logic            backupBusInhibit;

	assign alarm0Enable           = interruptControl[rtcbg_pkg::INTCTL_ALARM0_ENABLE_BIT];
	assign interruptRepeatSelect  = interruptControl[rtcbg_pkg::INTCTL_REPEAT_SELECT_BIT];
	assign backupSwitchoverSelect = backupConfig[rtcbg_pkg::CFG_SWITCHOVER_BIT];
	assign backupBusInhibit       = backupConfig[rtcbg_pkg::CFG_INHIBIT_BIT];

	// ----------------------------------------
	// Backup switchover and bus gating
	// ----------------------------------------
	logic next_onBattery;
	logic next_busEnable;
	logic next_memoryAccessEnable;

	always_comb begin
		if (backupSwitchoverSelect) begin
			next_onBattery = supply.vddBelowBattery && !supply.batteryBelowTrip;
		end else begin
			next_onBattery = supply.vddBelowTrip;
		end
		case ({backupBusInhibit, backupSwitchoverSelect})
			2'b01: begin
				next_busEnable = !next_onBattery || !supply.batteryBelowReset;
			end
			2'b11: begin
				next_busEnable = !supply.vddBelowBattery;
			end
			default: begin
				next_busEnable = !next_onBattery;
			end
		endcase
		if (supply.vddBelowReset) begin
			next_busEnable = 1'b0;
		end
		next_memoryAccessEnable = next_busEnable &&
			(!next_onBattery || ({backupBusInhibit, backupSwitchoverSelect} == 2'b01));
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			onBattery          <= 1'b0;
			busEnable          <= 1'b0;
			memoryAccessEnable <= 1'b0;
		end else if (ce) begin
			onBattery          <= next_onBattery;
			busEnable          <= next_busEnable;
			memoryAccessEnable <= next_memoryAccessEnable;
		end
	end

	// ----------------------------------------
	// Serial bus slave
	// ----------------------------------------
	rtcbg_pkg::rtcbg_bus_state_t state;
	logic [3:0]                  bitCount;
	logic [7:0]                  shiftReg;
	logic [7:0]                  txByte;
	logic [7:0]                  pointer;
	logic                        readMode;
	logic                        addressAck;
	logic                        hostNack;
	logic [7:0]                  loadAddr;
	logic [7:0]                  readValue;
	logic                        busActive;
	logic                        writeStrobe;
	logic                        loadStrobe;
	logic                        addressHit;

	assign busActive   = busEnable && !stopCond && !startCond && (state != rtcbg_pkg::ST_IDLE);
	assign writeStrobe = ce && busActive && sclFall && (bitCount == rtcbg_pkg::BIT_ACK_SLOT) &&
		(state == rtcbg_pkg::ST_WRITE_DATA);
	assign loadStrobe  = ce && busActive && sclFall && (bitCount == rtcbg_pkg::BIT_ACK_DONE) &&
		((state == rtcbg_pkg::ST_READ_DATA && !hostNack) ||
		(state == rtcbg_pkg::ST_DEVICE && addressAck && readMode));
	assign loadAddr    = (state == rtcbg_pkg::ST_READ_DATA) ? pointer + 8'h01 : pointer;
	assign addressHit  = shiftReg[7:1] == rtcbg_pkg::DEVICE_ADDRESS;

	always_comb begin
		readValue = 8'h00;
		if (loadAddr <= rtcbg_pkg::REG_ALARM0_WEEKDAY_MATCH) begin
			readValue = alarmReg[loadAddr[2:0]];
		end else if (loadAddr == rtcbg_pkg::REG_INTERRUPT_CONTROL) begin
			readValue = interruptControl;
		end else if (loadAddr == rtcbg_pkg::REG_STATUS) begin
			readValue[rtcbg_pkg::STATUS_ON_BATTERY_BIT]  = onBattery;
			readValue[rtcbg_pkg::STATUS_BUS_ENABLE_BIT]  = busEnable;
			readValue[rtcbg_pkg::STATUS_ALARM0_FLAG_BIT] = alarm0Flag;
		end else if (loadAddr == rtcbg_pkg::REG_BACKUP_CONFIG) begin
			readValue = backupConfig;
		end
	end

	// A supply drop abandons the transfer at once and releases the data line.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state      <= rtcbg_pkg::ST_IDLE;
			bitCount   <= 4'h0;
			shiftReg   <= 8'h00;
			txByte     <= 8'h00;
			pointer    <= 8'h00;
			readMode   <= 1'b0;
			addressAck <= 1'b0;
			hostNack   <= 1'b0;
			sdaOe      <= 1'b0;
			sdaOut     <= 1'b0;
		end else if (ce) begin
			sdaOut <= 1'b0;
			if (!busEnable || stopCond) begin
				state <= rtcbg_pkg::ST_IDLE;
				sdaOe <= 1'b0;
			end else if (startCond) begin
				state    <= rtcbg_pkg::ST_DEVICE;
				bitCount <= 4'h0;
				sdaOe    <= 1'b0;
			end else if (state != rtcbg_pkg::ST_IDLE) begin
				if (sclRise) begin
					bitCount <= bitCount + 4'h1;
					if (bitCount < rtcbg_pkg::BIT_ACK_SLOT) begin
						shiftReg <= {shiftReg[6:0], sdaS};
					end
					if (bitCount == rtcbg_pkg::BIT_ACK_SLOT) begin
						hostNack <= sdaS;
					end
				end else if (sclFall) begin
					if (bitCount == rtcbg_pkg::BIT_ACK_SLOT) begin
						case (state)
							rtcbg_pkg::ST_DEVICE: begin
								addressAck <= addressHit;
								readMode   <= shiftReg[0];
								sdaOe      <= addressHit;
							end
							rtcbg_pkg::ST_WORD_ADDR: begin
								pointer <= shiftReg;
								sdaOe   <= 1'b1;
							end
							rtcbg_pkg::ST_WRITE_DATA: begin
								pointer <= pointer + 8'h01;
								sdaOe   <= 1'b1;
							end
							default: begin
								sdaOe <= 1'b0;
							end
						endcase
					end else if (bitCount == rtcbg_pkg::BIT_ACK_DONE) begin
						bitCount <= 4'h0;
						sdaOe    <= 1'b0;
						if (loadStrobe) begin
							state   <= rtcbg_pkg::ST_READ_DATA;
							txByte  <= readValue;
							pointer <= loadAddr;
							sdaOe   <= !readValue[7];
						end else begin
							case (state)
								rtcbg_pkg::ST_DEVICE: begin
									state <= addressAck ? rtcbg_pkg::ST_WORD_ADDR : rtcbg_pkg::ST_IDLE;
								end
								rtcbg_pkg::ST_WORD_ADDR: begin
									state <= rtcbg_pkg::ST_WRITE_DATA;
								end
								rtcbg_pkg::ST_WRITE_DATA: begin
									state <= rtcbg_pkg::ST_WRITE_DATA;
								end
								default: begin
									state <= rtcbg_pkg::ST_IDLE;
								end
							endcase
						end
					end else if (state == rtcbg_pkg::ST_READ_DATA) begin
						sdaOe <= !txByte[3'(4'h7 - bitCount)];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			alarmReg         <= '0;
			interruptControl <= rtcbg_pkg::RESET_VALUE;
			backupConfig     <= rtcbg_pkg::RESET_VALUE;
		end else if (writeStrobe) begin
			if (pointer <= rtcbg_pkg::REG_ALARM0_WEEKDAY_MATCH) begin
				alarmReg[pointer[2:0]] <= shiftReg;
			end else if (pointer == rtcbg_pkg::REG_INTERRUPT_CONTROL) begin
				interruptControl <= shiftReg;
			end else if (pointer == rtcbg_pkg::REG_BACKUP_CONFIG) begin
				backupConfig <= shiftReg;
			end
		end
	end

	// ----------------------------------------
	// Alarm
	// ----------------------------------------
	localparam int PULSE_COUNT_W = rtcbg_pkg::PULSE_COUNT_W;

	logic                     alarmHit;
	logic                     statusReadClear;
	logic [PULSE_COUNT_W-1:0] pulseCount;

	rtcbg_alarm_match u_match (
		.clock       (clock),
		.rst_n       (rst_n),
		.ce          (ce),
		.compareReg  (alarmReg),
		.timeNow     (timeNow),
		.secondsTick (secondsTick),
		.hit         (alarmHit)
	);

	assign statusReadClear = loadStrobe && (loadAddr == rtcbg_pkg::REG_STATUS);

	// The flag is sticky; a match in the same cycle as the clearing read keeps it set.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			alarm0Flag <= 1'b0;
		end else if (ce) begin
			if (alarmHit) begin
				alarm0Flag <= 1'b1;
			end else if (statusReadClear) begin
				alarm0Flag <= 1'b0;
			end
		end
	end

	// The output path ignores the supply state so alarms still reach the pin on battery.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pulseCount            <= '0;
			interruptFreqOutput_n <= 1'b1;
		end else if (ce) begin
			if (alarmHit && alarm0Enable && interruptRepeatSelect) begin
				pulseCount <= PULSE_COUNT_W'(PULSE_CYCLES);
			end else if (pulseCount != '0) begin
				pulseCount <= pulseCount - 1'b1;
			end
			if (!alarm0Enable) begin
				interruptFreqOutput_n <= 1'b1;
			end else if (interruptRepeatSelect) begin
				interruptFreqOutput_n <= (pulseCount == '0);
			end else begin
				interruptFreqOutput_n <= !alarm0Flag;
			end
		end
	end

endmodule // rtcbg_top
`default_nettype wire

// ===== testbench/rtcbg_host.sv
// Two-wire bus host model that reaches the device registers.
`timescale 1ns/100ps
`default_nettype none
module rtcbg_host (
	input  wire logic clock,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaPull
);
	// Bus clock idles high between frames; a quarter bit is 20 ns, giving an 80 ns bit.
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end
	task automatic quarter();
		repeat (5) @(negedge clock);
	endtask
	task automatic sendBit(input logic b);
		sdaPull = !b;
		quarter();
		scl = 1'b1;
		quarter();
		quarter();
		scl = 1'b0;
		quarter();
	endtask
	task automatic getBit(output logic b);
		sdaPull = 1'b0;
		quarter();
		scl = 1'b1;
		quarter();
		b = sdaLine;
		quarter();
		scl = 1'b0;
		quarter();
	endtask
	task automatic start();
		sdaPull = 1'b0;
		quarter();
		scl = 1'b1;
		quarter();
		sdaPull = 1'b1;
		quarter();
		scl = 1'b0;
		quarter();
	endtask
	task automatic stop();
		sdaPull = 1'b1;
		quarter();
		scl = 1'b1;
		quarter();
		sdaPull = 1'b0;
		quarter();
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) sendBit(b[i]);
		getBit(a);
		ack = !a;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		sendByte({rtcbg_pkg::DEVICE_ADDRESS, 1'b0}, k0);
		sendByte(a, k1);
		sendByte(d, k2);
		stop();
		ok = k0 && k1 && k2;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k0, k1, k2;
		start();
		sendByte({rtcbg_pkg::DEVICE_ADDRESS, 1'b0}, k0);
		sendByte(a, k1);
		start();
		sendByte({rtcbg_pkg::DEVICE_ADDRESS, 1'b1}, k2);
		for (int i = 7; i >= 0; i--) getBit(d[i]);
		sendBit(1'b1);
		stop();
		ok = k0 && k1 && k2;
	endtask
endmodule // rtcbg_host
`default_nettype wire

// ===== testbench/rtcbg_props.sv
// Port-level assertions for the backup bus gating and alarm block.
`timescale 1ns/100ps
`default_nettype none
module rtcbg_props #(
	parameter int PULSE_CYCLES = rtcbg_pkg::PULSE_CYCLES
) (
	input wire logic                     clock,
	input wire logic                     rst_n,
	input wire logic                     ce,
	input wire logic                     sdaOe,
	input wire rtcbg_pkg::rtcbg_supply_t supplyRaw,
	input wire logic                     secondsTick,
	input wire logic                     interruptFreqOutput_n,
	input wire logic                     memoryAccessEnable,
	input wire logic                     busEnable,
	input wire logic                     onBattery,
	input wire logic                     alarm0Flag
);
	default clocking cb @(posedge clock); endclocking
	// A frozen clock enable stalls the synchronisers, so counted windows restart.
	default disable iff (!rst_n || !ce);
	sequence vddLowHeld;
		supplyRaw.vddBelowReset [*4];
	endsequence
	sequence mainsHeld;
		(!supplyRaw.vddBelowTrip && !supplyRaw.vddBelowBattery) [*4];
	endsequence
	sequence batteryLowHeld;
		($stable(supplyRaw) && supplyRaw.batteryBelowReset) [*4];
	endsequence
	sequence outputsAtReset;
		interruptFreqOutput_n && !busEnable && !onBattery && !alarm0Flag && !sdaOe;
	endsequence
	a_reset_bus_off: assert property (vddLowHeld |-> !busEnable)
		else $error("bus enabled below reset threshold");
	a_no_ack_off: assert property (!busEnable [*2] |-> !sdaOe)
		else $error("data line driven while bus disabled");
	a_memory_follows_bus: assert property ($stable(busEnable) [*2] |-> memoryAccessEnable == busEnable)
		else $error("memory access differs from bus enable");
	a_mains_not_backup: assert property (mainsHeld |-> !onBattery)
		else $error("backup entered with healthy supply");
	a_battery_low_bus: assert property (batteryLowHeld |-> !(onBattery && busEnable))
		else $error("bus live in backup with battery below reset");
	a_low_needs_flag: assert property ($fell(interruptFreqOutput_n) |-> alarm0Flag)
		else $error("alarm output low without alarm flag");
	a_flag_on_tick: assert property ($rose(alarm0Flag) |-> $past(secondsTick, 2))
		else $error("alarm flag rose away from a seconds update");
	a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=> outputsAtReset)
		else $error("outputs not at reset values");
endmodule // rtcbg_props
bind rtcbg_top rtcbg_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
	.clock(clock),
	.rst_n(rst_n),
	.ce(ce),
	.sdaOe(sdaOe),
	.supplyRaw(supplyRaw),
	.secondsTick(secondsTick),
	.interruptFreqOutput_n(interruptFreqOutput_n),
	.memoryAccessEnable(memoryAccessEnable),
	.busEnable(busEnable),
	.onBattery(onBattery),
	.alarm0Flag(alarm0Flag)
);
`default_nettype wire

// ===== testbench/tb_rtcbg_top.sv
// Self-checking bench for the backup bus gating and alarm block.
`timescale 1ns/100ps
`default_nettype none
module tb_rtcbg_top;
	localparam int PULSE = 8;
	logic                     clock;
	logic                     rst_n;
	logic                     ce;
	logic                     scl, sdaPull, sdaOut, sdaOe, ok;
	wire logic                sdaLine;
	rtcbg_pkg::rtcbg_supply_t supplyRaw;
	rtcbg_pkg::rtcbg_time_t   timeNow;
	logic                     secondsTick, irqN, memEn, busEn, onBat, flag;
	logic [7:0]               rdData;
	logic [4:0]               supplyCases [6] = '{5'h00, 5'h08, 5'h0a, 5'h10, 5'h18, 5'h1c};
	logic [7:0]               single [6] = '{8'h00, 8'hb0, 8'h91, 8'h81, 8'h81, 8'h00};
	int                       miscompares = 0;
	int                       checked = 0;
	// Open-drain data line with a pull-up.
	assign sdaLine = !(sdaPull || (sdaOe && !sdaOut));
	always #2 clock = ~clock;
	rtcbg_top #(.PULSE_CYCLES(PULSE)) u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .scl(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .supplyRaw(supplyRaw), .timeNow(timeNow), .secondsTick(secondsTick),
		.interruptFreqOutput_n(irqN), .memoryAccessEnable(memEn), .busEnable(busEn), .onBattery(onBat),
		.alarm0Flag(flag));
	rtcbg_host u_host (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic readCheck(input string what, input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, rdData, ok);
		check({what, " ack"}, ok, 8'h01);
		check(what, rdData, exp);
	endtask
	task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
		u_host.wr(a, d, ok);
		check("write ack", ok, 8'h01);
	endtask
	task automatic waitCycles(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic tick(input logic [7:0] h, input logic [7:0] mi, input logic [7:0] s);
		@(negedge clock);
		timeNow = {8'h03, 8'h01, 8'h01, h, mi, s};
		secondsTick = 1'b1;
		@(negedge clock);
		secondsTick = 1'b0;
	endtask
	// Returns memory, bus and backup expectations for a mode and a supply state.
	function automatic logic [2:0] gate(input logic [1:0] m, input rtcbg_pkg::rtcbg_supply_t s);
		logic bk, bs;
		bk = m[0] ? (s.vddBelowBattery && !s.batteryBelowTrip) : s.vddBelowTrip;
		if (!m[0])
			bs = !bk;
		else if (m[1])
			bs = !s.vddBelowBattery;
		else
			bs = !bk || !s.batteryBelowReset;
		bs = bs && !s.vddBelowReset;
		return {bs, bs, bk};
	endfunction
	initial begin
		repeat (80000) @(posedge clock);
		miscompares++;
		give_verdict();
	end
	initial begin
		logic [2:0] exp;
		clock = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		supplyRaw = '0;
		timeNow = '0;
		secondsTick = 1'b0;
		repeat (3) @(negedge clock);
		rst_n = 1'b1;
		waitCycles(6);
		for (int a = 0; a < 10; a++) readCheck("reset value", a[7:0], (a == 7) ? 8'h02 : 8'h00);
		$display("test reset done");
		// A low clock enable must hold the gating outputs even though the supply has dropped.
		ce = 1'b0;
		supplyRaw = 5'h10;
		waitCycles(6);
		check("frozen bus", busEn, 8'h01);
		ce = 1'b1;
		waitCycles(6);
		check("bus after freeze", busEn, 8'h00);
		supplyRaw = '0;
		waitCycles(6);
		$display("test freeze done");
		for (int m = 0; m < 4; m++) begin
			writeReg(rtcbg_pkg::REG_BACKUP_CONFIG, m[7:0]);
			for (int c = 0; c < 6; c++) begin
				supplyRaw = supplyCases[c];
				exp = gate(m[1:0], supplyCases[c]);
				waitCycles(6);
				check("backup", onBat, exp[0]);
				check("bus", busEn, exp[1]);
				check("memory", memEn, exp[2]);
				u_host.rd(rtcbg_pkg::REG_STATUS, rdData, ok);
				check("answer", ok, exp[1]);
				if (exp[1]) check("status", rdData, {6'h00, exp[1:0]});
				supplyRaw = '0;
				waitCycles(6);
			end
		end
		writeReg(rtcbg_pkg::REG_BACKUP_CONFIG, 8'h00);
		$display("test gating done");
		for (int i = 0; i < 6; i++) writeReg(i[7:0], single[i]);
		for (int i = 0; i < 6; i++) readCheck("compare", i[7:0], single[i]);
		writeReg(rtcbg_pkg::REG_INTERRUPT_CONTROL, 8'h20);
		tick(8'h11, 8'h29, 8'h59);
		waitCycles(5);
		check("flag early", flag, 8'h00);
		tick(8'h11, 8'h30, 8'h00);
		waitCycles(5);
		check("flag", flag, 8'h01);
		check("irq", irqN, 8'h00);
		tick(8'h11, 8'h30, 8'h01);
		waitCycles(40);
		check("irq held", irqN, 8'h00);
		readCheck("status", rtcbg_pkg::REG_STATUS, 8'h22);
		waitCycles(5);
		check("irq released", irqN, 8'h01);
		tick(8'h11, 8'h30, 8'h02);
		waitCycles(5);
		check("no rematch", flag, 8'h00);
		writeReg(rtcbg_pkg::REG_INTERRUPT_CONTROL, 8'h00);
		tick(8'h11, 8'h29, 8'h00);
		tick(8'h11, 8'h30, 8'h00);
		waitCycles(5);
		check("irq unarmed", irqN, 8'h01);
		$display("test single done");
		for (int i = 0; i < 6; i++) writeReg(i[7:0], (i == 0) ? 8'hb0 : 8'h00);
		writeReg(rtcbg_pkg::REG_INTERRUPT_CONTROL, 8'ha0);
		supplyRaw = 5'h14;
		waitCycles(6);
		check("on battery", onBat, 8'h01);
		for (int m = 0; m < 2; m++) begin
			tick(8'h12, m[7:0] + 8'h40, 8'h29);
			waitCycles(5);
			check("irq idle", irqN, 8'h01);
			tick(8'h12, m[7:0] + 8'h40, 8'h30);
			waitCycles(4);
			check("pulse", irqN, 8'h00);
			waitCycles(PULSE + 4);
			check("pulse end", irqN, 8'h01);
		end
		supplyRaw = '0;
		$display("test pulse done");
		give_verdict();
	end
endmodule // tb_rtcbg_top
`default_nettype wire
